// *** serial_shadow_ram_protect_tb.sv ***
// Testbench joining host end and device end over the serial link
`timescale 1ns/1ns
module serial_shadow_ram_protect_tb;
  logic        clk, rst_n, store_n, recall_n, cmd_valid, cmd_ready, rsp_valid;
  logic        prev_recall, write_en, store_busy, cs_p, sk_p, sb_p;
  logic [2:0]  cmd_op;
  logic [3:0]  cmd_addr;
  logic [15:0] cmd_wdata, rsp_rdata;
  logic [23:0] cap;
  int          num_errors, checks_done, cyc, stores;
  ssr_if lnk();
  ssr_host #(.SK_HALF(10)) ssr_host_i (.clk(clk), .rst_n(rst_n), .link(lnk),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  ssr_device #(.STORE_CYCLES(4)) ssr_device_i (.clk(clk), .rst_n(rst_n), .link(lnk),
    .store_n(store_n), .recall_n(recall_n), .prev_recall(prev_recall),
    .write_en(write_en), .store_busy(store_busy));
  ssr_monitor #(.SK_HALF(10)) ssr_monitor_i (.clk(clk), .rst_n(rst_n), .cs(lnk.cs),
    .sk(lnk.sk), .di(lnk.di), .dout(lnk.dout));
  always #4 clk = ~clk;
  // Wire capture, so framing is judged apart from the host
  always @(posedge clk) begin
    cs_p <= lnk.cs;
    sk_p <= lnk.sk;
    sb_p <= store_busy;
    if (store_busy === 1'b1 && sb_p === 1'b0) stores <= stores + 1;
    if (lnk.cs && !cs_p) cap <= 24'h00_0000;
    else if (lnk.cs && lnk.sk && !sk_p) cap <= {cap[22:0], lnk.di};
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cmd(input logic [2:0] op, input logic [3:0] a, input logic [15:0] w);
    logic d;
    d = (op == ssr_pkg::OP_WRITE) || (op == ssr_pkg::OP_READ);
    @(posedge clk);
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk("ready busy", 16'(cmd_ready), 16'h0000);
    do @(negedge clk); while (rsp_valid !== 1'b1);
    chk("ready idle", 16'(cmd_ready), 16'h0001);
    chk("instr", {8'h00, d ? cap[23:16] : cap[7:0]}, {8'h00, 1'b1, a, op});
    if (op == ssr_pkg::OP_WRITE) chk("wire data", cap[15:0], w);
  endtask : cmd
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    cmd(ssr_pkg::OP_READ, a, 16'h0000);
    chk("rdata", rsp_rdata, e);
  endtask : rd
  // Pin store: a falling edge, then time for the short store
  task automatic pin_store();
    @(posedge clk);
    store_n <= 1'b0;
    repeat (8) @(posedge clk);
    store_n <= 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
  endtask : pin_store
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 0; rst_n = 0; store_n = 1; recall_n = 1; cmd_valid = 0;
    cmd_op = 3'h0; cmd_addr = 4'h0; cmd_wdata = 16'h0000;
    num_errors = 0; checks_done = 0; cyc = 0; stores = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("recall latch", 16'(prev_recall), 16'h0000);
    chk("write latch", 16'(write_en), 16'h0000);
    cmd(ssr_pkg::OP_STORE, 4'h0, 16'h0000);
    chk("stores", 16'(stores), 16'h0000);
    cmd(ssr_pkg::OP_RECALL, 4'h0, 16'h0000);
    chk("recall latch", 16'(prev_recall), 16'h0001);
    cmd(ssr_pkg::OP_SET_WL, 4'h0, 16'h0000);
    chk("write latch", 16'(write_en), 16'h0001);
    // Unused opcode must leave the write latch alone
    cmd(3'h7, 4'h0, 16'h0000);
    chk("write latch", 16'(write_en), 16'h0001);
    cmd(ssr_pkg::OP_WRITE, 4'h5, 16'h1234);
    cmd(ssr_pkg::OP_WRITE, 4'h6, 16'h0f0f);
    rd(4'h5, 16'h1234);
    cmd(ssr_pkg::OP_CLR_WL, 4'h0, 16'h0000);
    chk("write latch", 16'(write_en), 16'h0000);
    cmd(ssr_pkg::OP_WRITE, 4'h5, 16'hbeef);
    rd(4'h5, 16'h1234);
    cmd(ssr_pkg::OP_STORE, 4'h0, 16'h0000);
    chk("stores", 16'(stores), 16'h0000);
    cmd(ssr_pkg::OP_SET_WL, 4'h0, 16'h0000);
    cmd(ssr_pkg::OP_STORE, 4'h0, 16'h0000);
    chk("stores", 16'(stores), 16'h0001);
    cmd(ssr_pkg::OP_WRITE, 4'h5, 16'h5555);
    rd(4'h6, 16'h0f0f);
    cmd(ssr_pkg::OP_RECALL, 4'h0, 16'h0000);
    rd(4'h5, 16'h1234);
    // Second reset in mid-run must drop both latches
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("write latch", 16'(write_en), 16'h0000);
    chk("recall latch", 16'(prev_recall), 16'h0000);
    pin_store();
    chk("stores", 16'(stores), 16'h0001);
    // Pins change on the rising edge only
    @(posedge clk);
    recall_n <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("recall latch", 16'(prev_recall), 16'h0001);
    cmd(ssr_pkg::OP_SET_WL, 4'h0, 16'h0000);
    chk("write latch", 16'(write_en), 16'h0000);
    rd(4'h5, 16'h0000);
    pin_store();
    chk("stores", 16'(stores), 16'h0001);
    @(posedge clk);
    recall_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(4'h5, 16'h1234);
    cmd(ssr_pkg::OP_SET_WL, 4'h0, 16'h0000);
    pin_store();
    chk("stores", 16'(stores), 16'h0002);
    wrap_up();
  end
endmodule : serial_shadow_ram_protect_tb

// *** ssr_device.sv ***
// Device end: serial decoder, protection latches, RAM and nonvolatile array
`timescale 1ns/1ns
module ssr_device #(
  parameter int STORE_CYCLES = ssr_pkg::STORE_CYCLES
) (
  input  wire logic clk,          // System clock
  input  wire logic rst_n,        // Synchronous reset, power-up
  ssr_if.device     link,         // Serial pins
  input  wire logic store_n,      // Store pin, active low
  input  wire logic recall_n,     // Array recall pin, active low
  output logic      prev_recall,  // Recall latch state
  output logic      write_en,     // Write latch state
  output logic      store_busy    // Store in progress
);
  localparam int W = ssr_pkg::WORD_W;
  localparam int N = ssr_pkg::WORDS;

  logic [1:0] cs_s, sk_s, di_s, st_s, rc_s;
  logic       sk_prev_q, st_prev_q;
  logic [ssr_pkg::CNT_W-1:0]  cnt_q;
  logic [7:0]                 instr_q;
  logic [W-1:0]               data_q, rd_q;
  logic                       rd_act_q, dout_q;
  logic                       prev_q, wen_q, busy_q;
  logic [ssr_pkg::BUSY_W-1:0] busy_cnt_q;
  logic [W-1:0]               ram [N];
  logic [W-1:0]               nv  [N];

  logic                       sk_rise, st_fall, recall_act, gate, both_set;
  logic [7:0]                 instr_now;
  logic [2:0]                 op_now, op_q;
  logic [ssr_pkg::ADDR_W-1:0] addr_now, addr_q;
  logic                       cmd_fire, wr_fire, store_go, recall_go, wr_go;

  // Two-flop synchronisers for every pin
  // Reset to idle pin levels, so no unknown or false edge follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s <= 2'h0;
      sk_s <= 2'h0;
      di_s <= 2'h0;
      st_s <= 2'h3;
      rc_s <= 2'h3;
    end else begin
      cs_s <= {cs_s[0], link.cs};
      sk_s <= {sk_s[0], link.sk};
      di_s <= {di_s[0], link.di};
      st_s <= {st_s[0], store_n};
      rc_s <= {rc_s[0], recall_n};
    end
  end

  // Edge history taken from second stages only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sk_prev_q <= 1'b0;
      st_prev_q <= 1'b1;
    end else begin
      sk_prev_q <= sk_s[1];
      st_prev_q <= st_s[1];
    end
  end

  assign sk_rise    = sk_s[1] & ~sk_prev_q & cs_s[1];
  assign st_fall    = st_prev_q & ~st_s[1];
  assign recall_act = ~rc_s[1];
  assign gate       = ~recall_act & ~busy_q;
  assign both_set   = prev_q & wen_q;

  assign instr_now = {instr_q[6:0], di_s[1]};
  assign op_now    = instr_now[2:0];
  assign addr_now  = instr_now[ssr_pkg::ADDR_LSB +: ssr_pkg::ADDR_W];
  assign op_q      = instr_q[2:0];
  assign addr_q    = instr_q[ssr_pkg::ADDR_LSB +: ssr_pkg::ADDR_W];

  // Command decode at byte end; word write after sixteen more bits
  assign cmd_fire = sk_rise && (cnt_q == 5'(ssr_pkg::INSTR_BITS - 1))
                    && instr_now[ssr_pkg::START_POS];
  assign wr_fire  = sk_rise && (cnt_q == 5'(ssr_pkg::FRAME_BITS - 1))
                    && instr_q[ssr_pkg::START_POS] && (op_q == ssr_pkg::OP_WRITE);

  assign store_go  = gate & both_set &
                     ((cmd_fire & (op_now == ssr_pkg::OP_STORE)) | st_fall);
  assign recall_go = (recall_act & ~busy_q) |
                     (gate & cmd_fire & (op_now == ssr_pkg::OP_RECALL));
  assign wr_go     = gate & both_set & wr_fire;

  always_ff @(posedge clk) begin
    if (!rst_n || !cs_s[1]) begin
      cnt_q   <= '0;
      instr_q <= '0;
      data_q  <= '0;
    end else if (sk_rise) begin
      if (cnt_q < 5'(ssr_pkg::INSTR_BITS)) begin
        instr_q <= instr_now;
      end else if (cnt_q < 5'(ssr_pkg::FRAME_BITS)) begin
        data_q <= {data_q[W-2:0], di_s[1]};
      end
      if (cnt_q < 5'(ssr_pkg::FRAME_BITS)) begin
        cnt_q <= cnt_q + 5'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !cs_s[1]) begin
      rd_act_q <= 1'b0;
      rd_q     <= '0;
      dout_q   <= 1'b0;
    end else if (cmd_fire && gate && op_now == ssr_pkg::OP_READ) begin
      rd_act_q <= 1'b1;
      rd_q     <= ram[addr_now];
      dout_q   <= ram[addr_now][W-1];
    end else if (sk_rise && rd_act_q) begin
      rd_q   <= {rd_q[W-2:0], 1'b0};
      dout_q <= rd_q[W-2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= ssr_pkg::LATCH_RST;
      wen_q  <= ssr_pkg::LATCH_RST;
    end else begin
      if (recall_go) begin
        prev_q <= 1'b1;
      end
      if (gate && cmd_fire) begin
        if (op_now == ssr_pkg::OP_SET_WL) begin
          wen_q <= 1'b1;
        end
        if (op_now == ssr_pkg::OP_CLR_WL) begin
          wen_q <= 1'b0;
        end
      end
    end
  end

  // store runs to the end, recall cannot abort it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (store_go) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= ssr_pkg::BUSY_W'(STORE_CYCLES);
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - ssr_pkg::BUSY_W'(1);
      if (busy_cnt_q == ssr_pkg::BUSY_W'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // whole array to RAM; write touches one word
  always_ff @(posedge clk) begin
    if (recall_go) begin
      for (int i = 0; i < N; i++) begin
        ram[i] <= nv[i];
      end
    end else if (wr_go) begin
      ram[addr_q] <= {data_q[W-2:0], di_s[1]};
    end
  end

  // store copies every word; snapshot taken at start
  always_ff @(posedge clk) begin
    if (store_go) begin
      for (int i = 0; i < N; i++) begin
        nv[i] <= ram[i];
      end
    end
  end

  assign link.dout   = dout_q;
  assign prev_recall = prev_q;
  assign write_en    = wen_q;
  assign store_busy  = busy_q;
endmodule : ssr_device

// *** ssr_host.sv ***
// Host end: frames one instruction with optional data word onto the serial pins
`timescale 1ns/1ns
module ssr_host #(
  parameter int SK_HALF = ssr_pkg::SK_HALF_CYC
) (
  input  wire logic        clk,        // System clock
  input  wire logic        rst_n,      // Synchronous reset
  ssr_if.host              link,       // Serial pins
  input  wire logic        cmd_valid,  // Command request
  input  wire logic [2:0]  cmd_op,     // Opcode
  input  wire logic [3:0]  cmd_addr,   // Word address
  input  wire logic [15:0] cmd_wdata,  // Write word
  output logic             cmd_ready,  // Idle, may take command
  output logic             rsp_valid,  // Frame finished, one cycle
  output logic [15:0]      rsp_rdata   // Read word
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP   = 3'b100
  } ssr_host_st_t;

  localparam logic [ssr_pkg::PH_W-1:0] PH_HI  = ssr_pkg::PH_W'(SK_HALF);
  localparam logic [ssr_pkg::PH_W-1:0] PH_END = ssr_pkg::PH_W'(2 * SK_HALF - 1);

  ssr_host_st_t st_q;
  logic [1:0]                 do_s;
  logic [ssr_pkg::PH_W-1:0]   ph_q;
  logic [ssr_pkg::CNT_W-1:0]  bit_q, nbits_q;
  logic [23:0]                sh_q;
  logic                       is_rd_q, cs_q, sk_q, di_q, ready_q, rv_q;
  logic [15:0]                rdata_q;

  // Device output crosses in through two flops
  always_ff @(posedge clk) begin
    do_s <= {do_s[0], link.dout};
  end

  // Frame sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      ph_q    <= '0;
      bit_q   <= '0;
      nbits_q <= '0;
      sh_q    <= '0;
      is_rd_q <= 1'b0;
      cs_q    <= 1'b0;
      sk_q    <= 1'b0;
      di_q    <= 1'b0;
      ready_q <= 1'b1;
      rv_q    <= 1'b0;
      rdata_q <= '0;
    end else begin
      rv_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_valid && ready_q) begin
            // address shifted above opcode; word follows
            sh_q    <= {1'b1, cmd_addr, cmd_op, cmd_wdata};
            nbits_q <= ssr_pkg::ssr_has_data(cmd_op) ?
                       5'(ssr_pkg::FRAME_BITS) : 5'(ssr_pkg::INSTR_BITS);
            is_rd_q <= (cmd_op == ssr_pkg::OP_READ);
            bit_q   <= '0;
            ph_q    <= '0;
            cs_q    <= 1'b1;
            ready_q <= 1'b0;
            st_q    <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          ph_q <= (ph_q == PH_END) ? '0 : ph_q + ssr_pkg::PH_W'(1);
          if (ph_q == '0) begin
            // data first, clock later; MSB first
            di_q <= sh_q[23];
            sk_q <= 1'b0;
          end
          if (ph_q == PH_HI) begin
            if (is_rd_q && bit_q >= 5'(ssr_pkg::INSTR_BITS)) begin
              rdata_q <= {rdata_q[14:0], do_s[1]};
            end
            sk_q <= 1'b1;
          end
          if (ph_q == PH_END) begin
            sh_q  <= {sh_q[22:0], 1'b0};
            bit_q <= bit_q + 5'd1;
            if (bit_q == nbits_q - 5'd1) begin
              st_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          ph_q <= (ph_q == PH_END) ? '0 : ph_q + ssr_pkg::PH_W'(1);
          if (ph_q == '0) begin
            sk_q <= 1'b0;
            di_q <= 1'b0;
          end
          if (ph_q == PH_HI) begin
            cs_q <= 1'b0;
          end
          if (ph_q == PH_END) begin
            rv_q    <= 1'b1;
            ready_q <= 1'b1;
            st_q    <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.cs   = cs_q;
  assign link.sk   = sk_q;
  assign link.di   = di_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdata_q;
endmodule : ssr_host

// *** ssr_if.sv ***
// Serial link between host and shadow RAM device
`timescale 1ns/1ns
interface ssr_if;
  logic cs;    // Select, high during a transfer
  logic sk;    // Serial clock from host
  logic di;    // Data into device
  logic dout;  // Data out of device
  modport host   (output cs, output sk, output di, input dout);
  modport device (input cs, input sk, input di, output dout);
endinterface : ssr_if

// *** ssr_monitor.sv ***
// Checker for the serial link between host end and device end
`timescale 1ns/1ns
module ssr_monitor #(
  parameter int SK_HALF = 10
) (
  input wire logic clk,   // Clock
  input wire logic rst_n, // Reset
  input wire logic cs,    // Select
  input wire logic sk,    // Serial clock
  input wire logic di,    // Data in
  input wire logic dout   // Data out
);
  logic [4:0] hi_q;
  logic [4:0] rise_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles of the current sk high phase
  always_ff @(posedge clk) begin
    if (!rst_n || !sk) hi_q <= 5'h00;
    else hi_q <= hi_q + 5'h01;
  end
  // Rising sk edges in this frame
  always_ff @(posedge clk) begin
    if (!rst_n || !cs) rise_q <= 5'h00;
    else if ($rose(sk)) rise_q <= rise_q + 5'h01;
  end
  sequence s_open; $rose(cs); endsequence
  sequence s_sk_low; !sk [*8]; endsequence
  property p_sk_idle; !cs |-> !sk; endproperty
  a_sk_idle: assert property (p_sk_idle) else $error("sk moved while idle");
  property p_di_hold; sk |-> $stable(di); endproperty
  a_di_hold: assert property (p_di_hold) else $error("di moved in sk high");
  property p_cs_open; s_open |-> s_sk_low; endproperty
  a_cs_open: assert property (p_cs_open) else $error("sk rose too soon");
  property p_sk_high; $fell(sk) |-> int'(hi_q) == SK_HALF; endproperty
  a_sk_high: assert property (p_sk_high) else $error("bad sk high length");
  property p_frame_len; $fell(cs) |-> rise_q == 5'h08 || rise_q == 5'h18; endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad bit count");
  property p_start; $rose(sk) && rise_q == 5'h00 |-> di; endproperty
  a_start: assert property (p_start) else $error("start bit low");
  property p_dout_idle; !cs [*8] |-> !dout; endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout busy idle");
  property p_dout_hold; $rose(sk) |-> ##7 $stable(dout) [*8]; endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout unstable");
endmodule : ssr_monitor

// *** ssr_pkg.sv ***
// Shared constants for the serial shadow RAM link, device end and host end
package ssr_pkg;
  // Array shape: 16 words of 16 bits
  localparam int WORD_W     = 16;
  localparam int WORDS      = 16;
  localparam int ADDR_W     = 4;
  localparam int OP_W       = 3;
  localparam int INSTR_BITS = 8;
  localparam int FRAME_BITS = INSTR_BITS + WORD_W;
  localparam int CNT_W      = 5;
  // Instruction byte fields: start bit, address, opcode
  localparam int START_POS  = 7;
  localparam int ADDR_LSB   = 3;
  // Opcodes in the low three bits
  localparam logic [2:0] OP_CLR_WL  = 3'h0;
  localparam logic [2:0] OP_STORE   = 3'h1;
  localparam logic [2:0] OP_WRITE   = 3'h3;
  localparam logic [2:0] OP_SET_WL  = 3'h4;
  localparam logic [2:0] OP_RECALL  = 3'h5;
  localparam logic [2:0] OP_READ    = 3'h6;
  // Timing
  localparam int CLK_NS       = 8;
  localparam int SK_HALF_NS   = 80;
  localparam int SK_HALF_CYC  = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYCLES = 64;
  localparam int PH_W         = 5;
  localparam int BUSY_W       = 13;
  // Reset values
  localparam logic LATCH_RST  = 1'b0;

  // Opcode carries a data word
  function automatic logic ssr_has_data(input logic [2:0] op);
    ssr_has_data = (op == OP_WRITE) || (op == OP_READ);
  endfunction : ssr_has_data
endpackage : ssr_pkg
